// ---- rtl/scpp_pkg.sv ----
package scpp_pkg;

	localparam logic [31:0] SCPP_KEY_FIRST    = 32'h83e7_0b13;
	localparam logic [31:0] SCPP_KEY_SECOND   = 32'h95a4_f1e0;

	// Word offsets in bytes.
	localparam logic [7:0]  SCPP_OFS_KEY0     = 8'h38;
	localparam logic [7:0]  SCPP_OFS_KEY1     = 8'h3c;
	localparam logic [7:0]  SCPP_OFS_PRI0     = 8'h10;
	localparam logic [7:0]  SCPP_OFS_PRI1     = 8'h14;
	localparam logic [7:0]  SCPP_OFS_PRI2     = 8'h18;
	localparam logic [7:0]  SCPP_OFS_CHIP2    = 8'h20;
	localparam logic [7:0]  SCPP_OFS_PUPD     = 8'h24;
	localparam logic [7:0]  SCPP_OFS_RXACT    = 8'h28;
	localparam logic [7:0]  SCPP_OFS_STATUS   = 8'h2c;

	localparam int          SCPP_BIT_PHY_PD   = 0;
	localparam int          SCPP_BIT_OTG_PD   = 1;

	// Eight 4-bit priority fields per word, only the low three bits used.
	localparam int          SCPP_PRI_W        = 3;
	localparam int          SCPP_NUM_MASTERS  = 24;
	localparam logic [31:0] SCPP_PRI0_RESET   = 32'h0000_0022;
	localparam logic [31:0] SCPP_PRI1_RESET   = 32'h0044_4000;
	localparam logic [31:0] SCPP_PRI2_RESET   = 32'h0000_6544;
	localparam logic [31:0] SCPP_CHIP2_RESET  = 32'h0000_0000;
	localparam logic [31:0] SCPP_PUPD_RESET   = 32'hffff_ffff;
	localparam logic [31:0] SCPP_RXACT_RESET  = 32'hffff_ffff;

	localparam logic [3:0]  SCPP_REV_NO_KEYS  = 4'h2;

	typedef enum logic [1:0] {
		SCPP_LOCKED  = 2'b00,
		SCPP_HALF    = 2'b01,
		SCPP_OPEN    = 2'b11
	} scpp_lock_t;

endpackage

// ---- rtl/scpp_arbiter.sv ----
`timescale 1ns/1ps
module scpp_arbiter #(
	parameter int NUM = 24,
	parameter int PW  = 3,
	parameter int IDW = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic [NUM-1:0]       req_i,
	input  wire logic [NUM*IDW-1:0]   id_i,
	input  wire logic [NUM*PW-1:0]    pri_i,
	output logic      [NUM-1:0]       grant_o,
	output logic      [IDW-1:0]       grant_id_o
);

	logic [NUM-1:0] next_grant;
	logic [IDW-1:0] next_id;

	// Lowest value wins, ties go to the lower port index.
	always_comb
	begin
		logic [PW-1:0] best;
		logic          found;
		best       = '1;
		found      = 1'b0;
		next_grant = '0;
		next_id    = '0;
		for (int i = 0; i < NUM; i++)
		begin
			if (req_i[i] && (!found || pri_i[i*PW +: PW] < best))
			begin
				best       = pri_i[i*PW +: PW];
				found      = 1'b1;
				next_grant = '0;
				next_grant[i] = 1'b1;
				next_id    = id_i[i*IDW +: IDW];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			grant_o    <= '0;
			grant_id_o <= '0;
		end
		else
		begin
			grant_o    <= next_grant;
			grant_id_o <= next_id;
		end
	end

endmodule

// ---- rtl/scpp_top.sv ----
`timescale 1ns/1ps
module scpp_top #(
	parameter logic [3:0] SILICON_REV = 4'h1,
	parameter int         NUM         = scpp_pkg::SCPP_NUM_MASTERS,
	parameter int         IDW         = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Classic Wishbone slave.
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	input  wire logic                 wb_priv_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Fabric requests.
	input  wire logic [NUM-1:0]       fab_req_i,
	input  wire logic [NUM*IDW-1:0]   fab_id_i,
	output logic      [NUM-1:0]       fab_grant_o,
	output logic      [IDW-1:0]       fab_grant_id_o,
	output logic      [NUM*3-1:0]     master_priority_o,
	// Power controls.
	output logic                      usb_phy_power_down_o,
	output logic                      usb_otg_power_down_o,
	output logic      [31:0]          input_receiver_enable_o,
	output logic      [31:0]          pull_resistor_enable_o,
	output logic                      unlocked_o
);

	//----------------------------------------
	// Register storage
	//----------------------------------------
	logic [31:0]          pri0;
	logic [31:0]          pri1;
	logic [31:0]          pri2;
	logic [31:0]          chip2;
	logic [31:0]          pupd;
	logic [31:0]          rxact;
	scpp_pkg::scpp_lock_t lock_state;
	logic                 keys_off;
	logic                 req;
	logic                 wr_ok;
	logic                 unlocked;
	logic [31:0]          rd_val;
	logic                 mapped;

	assign keys_off = (SILICON_REV >= scpp_pkg::SCPP_REV_NO_KEYS);
	assign unlocked = keys_off || (lock_state == scpp_pkg::SCPP_OPEN);
	assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;

	function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
						   input logic [31:0] new_v,
						   input logic [3:0]  sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign wr_ok = req && wb_we_i && wb_priv_i && unlocked;

	//----------------------------------------
	// Bus handshake
	//----------------------------------------
	// One wait state: ack in the cycle after the strobe is seen.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	//----------------------------------------
	// Key sequence
	//----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lock_state <= scpp_pkg::SCPP_LOCKED;
		else if (req && wb_we_i && wb_priv_i && !keys_off)
		begin
			if (hit(wb_adr_i, scpp_pkg::SCPP_OFS_KEY0))
			begin
				if (wb_dat_i == scpp_pkg::SCPP_KEY_FIRST)
				begin
					if (lock_state != scpp_pkg::SCPP_OPEN)
						lock_state <= scpp_pkg::SCPP_HALF;
				end
				else
					lock_state <= scpp_pkg::SCPP_LOCKED;
			end
			else if (hit(wb_adr_i, scpp_pkg::SCPP_OFS_KEY1))
			begin
				if (wb_dat_i != scpp_pkg::SCPP_KEY_SECOND)
					lock_state <= scpp_pkg::SCPP_LOCKED;
				else if (lock_state == scpp_pkg::SCPP_HALF)
					lock_state <= scpp_pkg::SCPP_OPEN;
			end
		end
	end

	//----------------------------------------
	// Configuration registers
	//----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pri0 <= scpp_pkg::SCPP_PRI0_RESET;
			pri1 <= scpp_pkg::SCPP_PRI1_RESET;
			pri2 <= scpp_pkg::SCPP_PRI2_RESET;
		end
		else if (wr_ok)
		begin
			if (hit(wb_adr_i, scpp_pkg::SCPP_OFS_PRI0))
				pri0 <= sel_merge(pri0, wb_dat_i, wb_sel_i);
			if (hit(wb_adr_i, scpp_pkg::SCPP_OFS_PRI1))
				pri1 <= sel_merge(pri1, wb_dat_i, wb_sel_i);
			if (hit(wb_adr_i, scpp_pkg::SCPP_OFS_PRI2))
				pri2 <= sel_merge(pri2, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			chip2 <= scpp_pkg::SCPP_CHIP2_RESET;
		else if (wr_ok && hit(wb_adr_i, scpp_pkg::SCPP_OFS_CHIP2))
			chip2 <= sel_merge(chip2, wb_dat_i, wb_sel_i) & 32'h0000_0003;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pupd  <= scpp_pkg::SCPP_PUPD_RESET;
			rxact <= scpp_pkg::SCPP_RXACT_RESET;
		end
		else if (wr_ok)
		begin
			if (hit(wb_adr_i, scpp_pkg::SCPP_OFS_PUPD))
				pupd <= sel_merge(pupd, wb_dat_i, wb_sel_i);
			if (hit(wb_adr_i, scpp_pkg::SCPP_OFS_RXACT))
				rxact <= sel_merge(rxact, wb_dat_i, wb_sel_i);
		end
	end

	//----------------------------------------
	// Read path
	//----------------------------------------
	always_comb
	begin
		mapped = 1'b1;
		unique case (wb_adr_i)
			scpp_pkg::SCPP_OFS_PRI0:   rd_val = pri0;
			scpp_pkg::SCPP_OFS_PRI1:   rd_val = pri1;
			scpp_pkg::SCPP_OFS_PRI2:   rd_val = pri2;
			scpp_pkg::SCPP_OFS_CHIP2:  rd_val = chip2;
			scpp_pkg::SCPP_OFS_PUPD:   rd_val = pupd;
			scpp_pkg::SCPP_OFS_RXACT:  rd_val = rxact;
			scpp_pkg::SCPP_OFS_STATUS: rd_val = {31'h0, unlocked};
			default:
			begin
				rd_val = 32'h0;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0;
		else if (req && !wb_we_i && wb_priv_i && mapped)
			wb_dat_o <= rd_val;
		else
			wb_dat_o <= 32'h0;
	end

	//----------------------------------------
	// Outputs to fabric and pads
	//----------------------------------------
	generate
		for (genvar m = 0; m < NUM; m++)
		begin : g_pri
			localparam logic [31:0] RST_WORD = (m < 8) ? scpp_pkg::SCPP_PRI0_RESET :
							   (m < 16) ? scpp_pkg::SCPP_PRI1_RESET :
							   scpp_pkg::SCPP_PRI2_RESET;
			logic [31:0] word;
			assign word = (m < 8) ? pri0 : (m < 16) ? pri1 : pri2;
			// Reset to the field's default so the fabric sees the register reset levels, zero for masters 2-10, 14-15 and 20-23.
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					master_priority_o[m*3 +: 3] <= RST_WORD[(m%8)*4 +: 3];
				else
					master_priority_o[m*3 +: 3] <= word[(m%8)*4 +: 3];
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			usb_phy_power_down_o    <= 1'b0;
			usb_otg_power_down_o    <= 1'b0;
			input_receiver_enable_o <= scpp_pkg::SCPP_RXACT_RESET;
			pull_resistor_enable_o  <= scpp_pkg::SCPP_PUPD_RESET;
			unlocked_o              <= 1'b0;
		end
		else
		begin
			usb_phy_power_down_o    <= chip2[scpp_pkg::SCPP_BIT_PHY_PD];
			usb_otg_power_down_o    <= chip2[scpp_pkg::SCPP_BIT_OTG_PD];
			input_receiver_enable_o <= rxact;
			pull_resistor_enable_o  <= pupd;
			unlocked_o              <= unlocked;
		end
	end

	scpp_arbiter #(
		.NUM (NUM),
		.PW  (3),
		.IDW (IDW)
	) u_arb (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.req_i      (fab_req_i),
		.id_i       (fab_id_i),
		.pri_i      (master_priority_o),
		.grant_o    (fab_grant_o),
		.grant_id_o (fab_grant_id_o)
	);

endmodule

// ---- dv/scpp_properties.sv ----
`timescale 1ns/1ps
module scpp_properties #(
	parameter logic [3:0] SILICON_REV = 4'h1,
	parameter int         NUM         = 24
) (
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic             wb_priv_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic [NUM-1:0]   fab_req_i,
	input wire logic [NUM-1:0]   fab_grant_o,
	input wire logic [NUM*3-1:0] master_priority_o,
	input wire logic             usb_phy_power_down_o,
	input wire logic             usb_otg_power_down_o,
	input wire logic [31:0]      input_receiver_enable_o,
	input wire logic [31:0]      pull_resistor_enable_o,
	input wire logic             unlocked_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic key2w;
	logic wrp;
	assign key2w = wb_we_i && wb_priv_i && wb_dat_i == scpp_pkg::SCPP_KEY_SECOND;
	assign wrp   = wb_cyc_i && wb_we_i && wb_priv_i;
	sequence quiet;
		!wb_cyc_i [*3];
	endsequence
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	dat_idle_a: assert property (!wb_ack_o || wb_we_i |-> wb_dat_o == 32'h0)
		else $error("read data outside read ack");
	user_read_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_priv_i
		|=> wb_dat_o == 32'h0) else $error("user read returned data");
	unlock_cause_a: assert property (SILICON_REV < 4'h2 && $rose(unlocked_o)
		|-> $past(key2w) || $past(key2w, 2)) else $error("unlock without second key");
	relock_cause_a: assert property ($fell(unlocked_o) |-> $past(wrp) || $past(wrp, 2))
		else $error("lock dropped without write");
	power_hold_a: assert property (quiet |=> $stable({usb_phy_power_down_o, usb_otg_power_down_o}))
		else $error("power control moved while idle");
	pad_hold_a: assert property (quiet |=> $stable({input_receiver_enable_o, pull_resistor_enable_o}))
		else $error("pad enables moved while idle");
	pri_hold_a: assert property (quiet |=> $stable(master_priority_o))
		else $error("priority moved while idle");
	grant_cause_a: assert property (|fab_grant_o
		|-> $onehot(fab_grant_o) && (fab_grant_o & $past(fab_req_i)) != '0)
		else $error("grant not one-hot or not requested");
	cover property ($rose(unlocked_o));
	cover property (|fab_grant_o);
	cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h0);
endmodule
bind scpp_top scpp_properties #(.SILICON_REV(SILICON_REV), .NUM(NUM)) i_scpp_properties (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_priv_i(wb_priv_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .fab_req_i(fab_req_i), .fab_grant_o(fab_grant_o),
	.master_priority_o(master_priority_o), .usb_phy_power_down_o(usb_phy_power_down_o),
	.usb_otg_power_down_o(usb_otg_power_down_o), .unlocked_o(unlocked_o),
	.input_receiver_enable_o(input_receiver_enable_o),
	.pull_resistor_enable_o(pull_resistor_enable_o));

// ---- dv/scpp_fabric_model.sv ----
`timescale 1ns/1ps
module scpp_fabric_model #(
	parameter int NUM = 24
) (
	input  wire logic             clk_i,
	input  wire logic [NUM-1:0]   req_mask_i,
	output logic      [NUM-1:0]   fab_req_o,
	output logic      [NUM*8-1:0] fab_id_o
);
	initial fab_req_o = '0;
	always_comb
		for (int i = 0; i < NUM; i++)
			fab_id_o[i*8+:8] = 8'(i * 3 + 1);
	always @(posedge clk_i)
		fab_req_o <= req_mask_i;
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic         clk_i;
	logic         rst_i;
	logic         cs;
	logic         we;
	logic         priv;
	logic [7:0]   adr;
	logic [31:0]  wdat;
	logic [3:0]   sel;
	logic [31:0]  rdat;
	logic         ack;
	logic [23:0]  req_mask;
	logic [23:0]  req;
	logic [191:0] ids;
	logic [23:0]  grant;
	logic [7:0]   grant_id;
	logic [71:0]  pri;
	logic         phy_pd;
	logic         otg_pd;
	logic [31:0]  rx_en;
	logic [31:0]  pu_en;
	logic         unl;
	logic         unl2;
	logic [31:0]  v;
	logic [31:0]  expq[$];
	int           err_total;
	int           num_checks;
	scpp_top i_scpp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cs), .wb_stb_i(cs),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_priv_i(priv),
		.wb_dat_o(rdat), .wb_ack_o(ack), .fab_req_i(req), .fab_id_i(ids), .fab_grant_o(grant),
		.fab_grant_id_o(grant_id), .master_priority_o(pri), .usb_phy_power_down_o(phy_pd),
		.usb_otg_power_down_o(otg_pd), .input_receiver_enable_o(rx_en),
		.pull_resistor_enable_o(pu_en), .unlocked_o(unl));
	scpp_top #(.SILICON_REV(4'h2)) i_scpp_top_rev2 (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_priv_i(priv), .wb_dat_o(), .wb_ack_o(), .fab_req_i(req),
		.fab_id_i(ids), .fab_grant_o(), .fab_grant_id_o(), .master_priority_o(),
		.usb_phy_power_down_o(), .usb_otg_power_down_o(), .input_receiver_enable_o(),
		.pull_resistor_enable_o(), .unlocked_o(unl2));
	scpp_fabric_model i_scpp_fabric_model (.clk_i(clk_i), .req_mask_i(req_mask),
		.fab_req_o(req), .fab_id_o(ids));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic p);
		cs <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		priv <= p;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		cs <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic p, input logic [31:0] e);
		expq.push_back(e);
		wb(1'b0, a, 32'h0, p);
	endtask
	task automatic unlock();
		wb(1'b1, scpp_pkg::SCPP_OFS_KEY0, scpp_pkg::SCPP_KEY_FIRST, 1'b1);
		wb(1'b1, scpp_pkg::SCPP_OFS_KEY1, scpp_pkg::SCPP_KEY_SECOND, 1'b1);
	endtask
	task automatic fab(input logic [23:0] m, input logic [23:0] g, input logic [7:0] id);
		req_mask <= m;
		repeat (3) @(posedge clk_i);
		chk({8'h0, grant}, {8'h0, g}, "grant");
		chk({24'h0, grant_id}, {24'h0, id}, "grant id");
	endtask
	task automatic end_of_test();
		$display("checks %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0)
			chk(rdat, expq.pop_front(), "read data");
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_of_test();
	end
	initial
	begin
		{rst_i, cs, we, priv, adr, wdat, req_mask, err_total, num_checks} = '0;
		sel = 4'hf;
		rst_i = 1'b1;
		void'($urandom(66795));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(scpp_pkg::SCPP_OFS_PRI1, 1'b1, scpp_pkg::SCPP_PRI1_RESET);
		rd(scpp_pkg::SCPP_OFS_PUPD, 1'b1, scpp_pkg::SCPP_PUPD_RESET);
		rd(scpp_pkg::SCPP_OFS_RXACT, 1'b1, scpp_pkg::SCPP_RXACT_RESET);
		v = $urandom() & 32'h7777_7777;
		wb(1'b1, scpp_pkg::SCPP_OFS_PRI0, v, 1'b1);
		rd(scpp_pkg::SCPP_OFS_PRI0, 1'b1, scpp_pkg::SCPP_PRI0_RESET);
		wb(1'b1, scpp_pkg::SCPP_OFS_KEY0, scpp_pkg::SCPP_KEY_FIRST, 1'b0);
		wb(1'b1, scpp_pkg::SCPP_OFS_KEY1, scpp_pkg::SCPP_KEY_SECOND, 1'b0);
		chk({31'h0, unl}, 32'h0, "unlocked by user");
		wb(1'b1, scpp_pkg::SCPP_OFS_KEY1, scpp_pkg::SCPP_KEY_SECOND, 1'b1);
		chk({31'h0, unl}, 32'h0, "unlocked out of order");
		unlock();
		rd(scpp_pkg::SCPP_OFS_STATUS, 1'b1, 32'h1);
		wb(1'b1, scpp_pkg::SCPP_OFS_PRI0, v, 1'b1);
		wb(1'b1, scpp_pkg::SCPP_OFS_PRI0, ~v, 1'b0);
		rd(scpp_pkg::SCPP_OFS_PRI0, 1'b1, v);
		rd(scpp_pkg::SCPP_OFS_PRI0, 1'b0, 32'h0);
		rd(scpp_pkg::SCPP_OFS_KEY0, 1'b0, 32'h0);
		rd(8'hf0, 1'b1, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			wb(1'b1, scpp_pkg::SCPP_OFS_CHIP2, 32'(k), 1'b1);
			chk({30'h0, otg_pd, phy_pd}, 32'(k), "power down pair");
		end
		v = $urandom();
		wb(1'b1, scpp_pkg::SCPP_OFS_PUPD, v, 1'b1);
		wb(1'b1, scpp_pkg::SCPP_OFS_RXACT, ~v, 1'b1);
		chk(pu_en, v, "pull enables");
		chk(rx_en, ~v, "receiver enables");
		sel <= 4'h1;
		wb(1'b1, scpp_pkg::SCPP_OFS_RXACT, 32'h0, 1'b1);
		sel <= 4'hf;
		chk(rx_en, {~v[31:8], 8'h00}, "receiver byte lane");
		wb(1'b1, scpp_pkg::SCPP_OFS_PRI0, 32'h0000_1757, 1'b1);
		chk({20'h0, pri[11:0]}, 32'h3ef, "priority fields");
		fab(24'h7, 24'h2, 8'h04);
		fab(24'ha, 24'h8, 8'h0a);
		fab(24'h5, 24'h1, 8'h01);
		for (int j = 0; j < 2; j++)
		begin
			unlock();
			wb(1'b1, j ? scpp_pkg::SCPP_OFS_KEY1 : scpp_pkg::SCPP_OFS_KEY0, $urandom(), 1'b1);
			chk({31'h0, unl}, 32'h0, "relock");
		end
		wb(1'b1, scpp_pkg::SCPP_OFS_PRI0, 32'h0, 1'b1);
		rd(scpp_pkg::SCPP_OFS_PRI0, 1'b1, 32'h0000_1757);
		unlock();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({8'h0, pri[23:0]}, 32'h0000_0012, "priority defaults");
		chk({31'h0, unl}, 32'h0, "locked after reset");
		rd(scpp_pkg::SCPP_OFS_PRI0, 1'b1, scpp_pkg::SCPP_PRI0_RESET);
		chk({31'h0, unl2}, 32'h1, "revision two unlocked");
		end_of_test();
	end
endmodule
